/* File: core/clock_mode_consts.vh */
// constants for the system clock and operating mode control block
`ifndef CLOCK_MODE_CONSTS_VH
`define CLOCK_MODE_CONSTS_VH

// register byte offsets
`define OFS_SYS_CLOCK_CONTROL  8'h00
`define OFS_FAST_OSC_CONTROL   8'h04
`define OFS_IRQ_STATUS         8'h08
`define OFS_IRQ_CLEAR          8'h0c
`define OFS_IRQ_ENABLE         8'h10

// system_clock_control fields
`define SYS_SEL_HI             7
`define SYS_SEL_LO             5
`define SYS_FAST_KEEP          1
`define SYS_SLOW_KEEP          0
`define SYS_RESET_SEL          3'h0

// fast_osc_control fields
`define FOC_FREQ_HI            3
`define FOC_FREQ_LO            2
`define FOC_STABLE             1
`define FOC_ENABLE             0
`define FOC_RESET_FREQ         2'h0

// source select codes
`define SEL_LOW_SPEED          3'h7

// fast rc frequency codes and their values in MHz
`define FREQ_CODE_12           2'h1
`define FREQ_CODE_16           2'h2
`define FREQ_MHZ_8             5'h08
`define FREQ_MHZ_12            5'h0c
`define FREQ_MHZ_16            5'h10

// operating modes
`define MODE_FAST              3'h0
`define MODE_SLOW              3'h1
`define MODE_SLEEP             3'h2
`define MODE_IDLE_SLOW_ONLY    3'h3
`define MODE_IDLE_BOTH_CLOCKS  3'h4
`define MODE_IDLE_FAST_ONLY    3'h5

// interrupt bit positions
`define IRQ_SWITCH_DONE        0
`define IRQ_FAST_STABLE        1
`define IRQ_HALT_ENTERED       2
`define IRQ_WIDTH              3

// timing
`define CLK_PERIOD_NS          40
`define FAST_SETTLE_NS         200
`define FAST_SETTLE_CYCLES     ((`FAST_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W           4

`endif

/* File: core/system_clock_mode_control.v */
// system clock source switching, fast rc control and halt mode selection behind an ahb-lite slave
// Operation
// - select codes 000..110 give fast clock divided 1..64, 111 the slow clock.
// - fast oscillator keeps running during halt only if its halt keep bit is 1.
// - slow oscillator keeps running during halt only if its halt keep bit is 1.
// - unimplemented bits of both clock control registers read as zero.
// - source switch completes within four system periods plus edge alignment waits.
// - fast rc frequency code 00 is 8, 01 12, 10 16, 11 8 MHz.
// - new fast rc frequency is applied only once the stable flag is set.
// - read-only stable flag reads 0 while unstable, 1 once stable.
// - enabling fast rc first clears stable flag, then sets it when stabilised.
// - fast rc enable bit is read/write and resets to 1.
// - fast/slow switching only via select field; halt picks idle or sleep.
// - switching to 111 completes only once the slow rc oscillator is stable.
// - halt keep bits pick sleep, idle slow only, idle both or idle fast only.
// - fast clock comes from fast rc, slow clock from slow rc oscillator.
// - in slow operation fast clock runs or stops per its enable bit.
`timescale 1ns/10ps
`include "clock_mode_consts.vh"

module system_clock_mode_control #(
	parameter DIV_W = 6                   // fast clock divider width
) (
	input  wire        CLK,               // system clock
	input  wire        SRST,              // synchronous reset, high
	input  wire        CE,                // clock enable, freezes state when low
	input  wire        HSEL,              // ahb slave select
	input  wire [7:0]  HADDR,             // ahb address, low byte
	input  wire [1:0]  HTRANS,            // ahb transfer type
	input  wire        HWRITE,            // ahb write
	input  wire [2:0]  HSIZE,             // ahb size
	input  wire [31:0] HWDATA,            // ahb write data
	input  wire        HREADY,            // ahb bus ready
	output reg  [31:0] HRDATA,            // ahb read data
	output reg         HREADYOUT,         // ahb slave ready
	output reg         HRESP,             // ahb response, always okay
	input  wire        HS_CLK_IN,         // fast rc oscillator output
	input  wire        LS_CLK_IN,         // slow rc oscillator output
	input  wire        FAST_RC_READY,     // fast rc analog ready
	input  wire        SLOW_RC_READY,     // slow rc analog ready
	input  wire        HALT_REQ,          // halt instruction pulse from cpu
	input  wire        WAKE_REQ,          // wake-up pulse
	output reg         SYSCLK,            // gated system clock level
	output reg         FAST_RC_ON,        // fast rc oscillator enable
	output reg         SLOW_RC_ON,        // slow rc oscillator enable
	output reg  [4:0]  FAST_RC_MHZ,       // applied fast rc frequency
	output reg  [2:0]  MODE,              // operating mode
	output reg         IRQ                // level interrupt
);

	localparam ST_RUN      = 2'h0;
	localparam ST_CUR_LOW  = 2'h1;
	localparam ST_TAR_LOW  = 2'h2;

	reg  [3:0]            sync1;
	reg  [3:0]            sync2;
	reg                   hs_prev;
	reg  [DIV_W-1:0]      div_cnt;
	reg  [2:0]            sel;
	reg  [2:0]            active_sel;
	reg                   fast_keep;
	reg                   slow_keep;
	reg  [1:0]            freq_sel;
	reg                   fast_en;
	reg                   stable;
	reg  [`SETTLE_CNT_W-1:0] settle;
	reg  [1:0]            sw_state;
	reg                   halted;
	reg  [`IRQ_WIDTH-1:0] irq_status;
	reg  [`IRQ_WIDTH-1:0] irq_enable;
	reg                   wr_pend;
	reg                   rd_pend;
	reg  [7:0]            ph_addr;
	reg  [31:0]           rd_mux;
	reg  [4:0]            next_mhz;
	reg                   cur_lvl;
	reg                   tar_lvl;
	wire                  hs_s;
	wire                  ls_s;
	wire                  fast_rdy_s;
	wire                  slow_rdy_s;
	wire                  accept;
	wire                  wr_sysctl;
	wire                  wr_foc;
	wire                  restart_settle;
	wire                  stable_set;
	wire                  switch_done;
	wire                  halt_enter;
	wire [`IRQ_WIDTH-1:0] irq_set;
	wire [`IRQ_WIDTH-1:0] irq_clr;

	assign hs_s       = sync2[0];
	assign ls_s       = sync2[1];
	assign fast_rdy_s = sync2[2];
	assign slow_rdy_s = sync2[3];

	//////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always @(posedge CLK) begin
		if (SRST) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else if (CE) begin
			sync1 <= {SLOW_RC_READY, FAST_RC_READY, LS_CLK_IN, HS_CLK_IN};
			sync2 <= sync1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave

	assign accept = HSEL & HTRANS[1] & HREADY;
	assign wr_sysctl = wr_pend & (ph_addr == `OFS_SYS_CLOCK_CONTROL);
	assign wr_foc = wr_pend & (ph_addr == `OFS_FAST_OSC_CONTROL);
	assign irq_clr = (wr_pend & (ph_addr == `OFS_IRQ_CLEAR)) ? HWDATA[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

	always @* begin
		rd_mux = 32'h0;
		case (ph_addr)
			`OFS_SYS_CLOCK_CONTROL: begin
				rd_mux[`SYS_SEL_HI:`SYS_SEL_LO] = sel;
				rd_mux[`SYS_FAST_KEEP]          = fast_keep;
				rd_mux[`SYS_SLOW_KEEP]          = slow_keep;
			end
			`OFS_FAST_OSC_CONTROL: begin
				rd_mux[`FOC_FREQ_HI:`FOC_FREQ_LO] = freq_sel;
				rd_mux[`FOC_STABLE]               = stable;
				rd_mux[`FOC_ENABLE]               = fast_en;
			end
			`OFS_IRQ_STATUS: rd_mux[`IRQ_WIDTH-1:0] = irq_status;
			`OFS_IRQ_ENABLE: rd_mux[`IRQ_WIDTH-1:0] = irq_enable;
			default: rd_mux = 32'h0;
		endcase
	end

	always @(posedge CLK) begin
		if (SRST) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			ph_addr   <= 8'h00;
			HRDATA    <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else if (CE) begin
			if (rd_pend) begin
				// read data one wait state after the address phase
				HRDATA    <= rd_mux;
				HREADYOUT <= 1'b1;
				rd_pend   <= 1'b0;
				wr_pend   <= 1'b0;
			end else if (accept) begin
				ph_addr   <= HADDR;
				wr_pend   <= HWRITE;
				rd_pend   <= ~HWRITE;
				HREADYOUT <= HWRITE;
			end else begin
				wr_pend <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// control registers

	always @(posedge CLK) begin
		if (SRST) begin
			sel        <= `SYS_RESET_SEL;
			fast_keep  <= 1'b0;
			slow_keep  <= 1'b0;
			freq_sel   <= `FOC_RESET_FREQ;
			fast_en    <= 1'b1;
			irq_enable <= {`IRQ_WIDTH{1'b0}};
		end else if (CE) begin
			if (wr_sysctl) begin
				sel       <= HWDATA[`SYS_SEL_HI:`SYS_SEL_LO];
				fast_keep <= HWDATA[`SYS_FAST_KEEP];
				slow_keep <= HWDATA[`SYS_SLOW_KEEP];
			end
			if (wr_foc) begin
				freq_sel <= HWDATA[`FOC_FREQ_HI:`FOC_FREQ_LO];
				fast_en  <= HWDATA[`FOC_ENABLE];
			end
			if (wr_pend & (ph_addr == `OFS_IRQ_ENABLE))
				irq_enable <= HWDATA[`IRQ_WIDTH-1:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// fast rc stability and frequency

	// enable rising or frequency change restarts
	assign restart_settle = wr_foc & ((HWDATA[`FOC_ENABLE] & ~fast_en) |
		(HWDATA[`FOC_FREQ_HI:`FOC_FREQ_LO] != freq_sel));
	assign stable_set = ~stable & fast_en & fast_rdy_s & ~restart_settle & (settle == `FAST_SETTLE_CYCLES);

	always @* begin
		case (freq_sel)
			`FREQ_CODE_12: next_mhz = `FREQ_MHZ_12;
			`FREQ_CODE_16: next_mhz = `FREQ_MHZ_16;
			default:       next_mhz = `FREQ_MHZ_8;
		endcase
	end

	always @(posedge CLK) begin
		if (SRST) begin
			stable      <= 1'b0;
			settle      <= {`SETTLE_CNT_W{1'b0}};
			FAST_RC_MHZ <= `FREQ_MHZ_8;
		end else if (CE) begin
			if (restart_settle | ~fast_en | ~fast_rdy_s) begin
				stable <= 1'b0;
				settle <= {`SETTLE_CNT_W{1'b0}};
			end else if (settle != `FAST_SETTLE_CYCLES) begin
				settle <= settle + 1'b1;
			end
			if (stable_set) begin
				stable      <= 1'b1;
				FAST_RC_MHZ <= next_mhz;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// clock source selection

	function src_level;
		input [2:0]       code;
		input             hs;
		input             ls;
		input [DIV_W-1:0] cnt;
		begin
			if (code == `SEL_LOW_SPEED)
				src_level = ls;
			else if (code == 3'h0)
				src_level = hs;
			else
				src_level = cnt[code - 3'h1];
		end
	endfunction

	always @* begin
		// fast from fast rc, slow from slow rc
		cur_lvl = src_level(active_sel, hs_s, ls_s, div_cnt);
		tar_lvl = src_level(sel, hs_s, ls_s, div_cnt);
	end

	// slow target waits for slow rc stable
	assign switch_done = (sw_state == ST_TAR_LOW) & ~tar_lvl &
		((sel == `SEL_LOW_SPEED) ? slow_rdy_s : stable);

	always @(posedge CLK) begin
		if (SRST) begin
			hs_prev    <= 1'b0;
			div_cnt    <= {DIV_W{1'b0}};
			active_sel <= `SYS_RESET_SEL;
			sw_state   <= ST_RUN;
			SYSCLK     <= 1'b0;
		end else if (CE) begin
			hs_prev <= hs_s;
			if (hs_s & ~hs_prev)
				div_cnt <= div_cnt + 1'b1;
			case (sw_state)
				ST_RUN: begin
					if (sel != active_sel)
						sw_state <= ST_CUR_LOW;
					SYSCLK <= cur_lvl & ~halted;
				end
				ST_CUR_LOW: begin
					if (~cur_lvl)
						sw_state <= ST_TAR_LOW;
					SYSCLK <= cur_lvl & ~halted;
				end
				ST_TAR_LOW: begin
					if (switch_done) begin
						active_sel <= sel;
						sw_state   <= ST_RUN;
					end
					SYSCLK <= 1'b0;
				end
				default: begin
					sw_state <= ST_RUN;
					SYSCLK   <= 1'b0;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// halt modes and oscillator enables

	assign halt_enter = HALT_REQ & ~halted;

	always @(posedge CLK) begin
		if (SRST) begin
			halted     <= 1'b0;
			MODE       <= `MODE_FAST;
			FAST_RC_ON <= 1'b1;
			SLOW_RC_ON <= 1'b1;
		end else if (CE) begin
			if (halt_enter)
				halted <= 1'b1;
			else if (WAKE_REQ)
				halted <= 1'b0;
			if (halted)
				case ({fast_keep, slow_keep})
					2'h0:    MODE <= `MODE_SLEEP;
					2'h1:    MODE <= `MODE_IDLE_SLOW_ONLY;
					2'h3:    MODE <= `MODE_IDLE_BOTH_CLOCKS;
					default: MODE <= `MODE_IDLE_FAST_ONLY;
				endcase
			else
				MODE <= (active_sel == `SEL_LOW_SPEED) ? `MODE_SLOW : `MODE_FAST;
			// fast oscillator in halt; enable bit governs when running
			FAST_RC_ON <= fast_en & (~halted | fast_keep);
			SLOW_RC_ON <= ~halted | slow_keep;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// interrupts

	assign irq_set = {halt_enter, stable_set, switch_done};

	always @(posedge CLK) begin
		if (SRST) begin
			irq_status <= {`IRQ_WIDTH{1'b0}};
			IRQ        <= 1'b0;
		end else if (CE) begin
			// set wins over clear
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			IRQ        <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
		end
	end

endmodule // system_clock_mode_control

/* File: bench/clock_mode_monitor.sv */
// port checker for the clock and mode control block
`timescale 1ns/10ps
`include "clock_mode_consts.vh"
////////////////////////////////////////////////////////////
module clock_mode_monitor (
	input wire       CLK,         // clock
	input wire       SRST,        // reset
	input wire       CE,          // clock enable
	input wire       HSEL,        // select
	input wire [1:0] HTRANS,      // transfer type
	input wire       HWRITE,      // write
	input wire       HREADY,      // bus ready
	input wire       HREADYOUT,   // slave ready
	input wire       HALT_REQ,    // halt pulse
	input wire       WAKE_REQ,    // wake pulse
	input wire       SYSCLK,      // system clock level
	input wire       FAST_RC_ON,  // fast osc enable
	input wire       SLOW_RC_ON,  // slow osc enable
	input wire [4:0] FAST_RC_MHZ, // applied frequency
	input wire [2:0] MODE         // operating mode
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_sleep_osc_off: assert property (MODE == `MODE_SLEEP |-> !FAST_RC_ON && !SLOW_RC_ON)
		else $error("oscillator on in sleep");
	a_idle_slow_osc: assert property (MODE == `MODE_IDLE_SLOW_ONLY |-> !FAST_RC_ON && SLOW_RC_ON)
		else $error("wrong oscillators in slow idle");
	a_idle_both_osc: assert property (MODE == `MODE_IDLE_BOTH_CLOCKS |-> SLOW_RC_ON)
		else $error("slow oscillator off in dual idle");
	a_idle_fast_osc: assert property (MODE == `MODE_IDLE_FAST_ONLY |-> !SLOW_RC_ON)
		else $error("slow oscillator on in fast idle");
	a_halt_clk_stop: assert property (MODE >= `MODE_SLEEP |-> !SYSCLK)
		else $error("system clock runs while halted");
	a_halt_enters: assert property (CE && HALT_REQ && !WAKE_REQ && MODE < `MODE_SLEEP |-> ##2 MODE >= `MODE_SLEEP)
		else $error("halt not entered");
	a_wake_leaves: assert property (CE && WAKE_REQ && MODE >= `MODE_SLEEP |-> ##2 MODE < `MODE_SLEEP)
		else $error("halt not left");
	a_freq_legal: assert property (FAST_RC_MHZ == 5'h08 || FAST_RC_MHZ == 5'h0c || FAST_RC_MHZ == 5'h10)
		else $error("illegal fast frequency");
	a_read_wait: assert property (CE && HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
endmodule // clock_mode_monitor

bind system_clock_mode_control clock_mode_monitor mon (.CLK, .SRST, .CE, .HSEL, .HTRANS, .HWRITE, .HREADY,
	.HREADYOUT, .HALT_REQ, .WAKE_REQ, .SYSCLK, .FAST_RC_ON, .SLOW_RC_ON, .FAST_RC_MHZ, .MODE);

/* File: bench/tb_top.sv */
// self-checking bench for the clock and mode control block
`timescale 1ns/10ps
`include "clock_mode_consts.vh"
////////////////////////////////////////////////////////////
module tb_top;
	reg         clk, srst, hsel, hwrite, halt, wake, frdy, srdy;
	reg  [7:0]  haddr, cnt;
	reg  [1:0]  htrans;
	reg  [31:0] hwdata, q;
	wire [31:0] hrdata;
	wire        hrdyo, hresp, sysclk, fon, son, irq;
	wire [4:0]  mhz;
	wire [2:0]  mode;
	integer     errors, checks_done;

	system_clock_mode_control DUT (.CLK(clk), .SRST(srst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdyo), .HRDATA(hrdata),
		.HREADYOUT(hrdyo), .HRESP(hresp), .HS_CLK_IN(cnt[1]), .LS_CLK_IN(cnt[3]), .FAST_RC_READY(frdy),
		.SLOW_RC_READY(srdy), .HALT_REQ(halt), .WAKE_REQ(wake), .SYSCLK(sysclk), .FAST_RC_ON(fon),
		.SLOW_RC_ON(son), .FAST_RC_MHZ(mhz), .MODE(mode), .IRQ(irq));
////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// oscillators: fast period 4 cycles, slow 16
	always @(posedge clk) cnt <= srst ? 8'h00 : cnt + 8'h01;

	task chk(input [31:0] s, input [31:0] e, input string n);
		checks_done = checks_done + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task bus(input w, input [7:0] a, input [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge clk);
		while (hrdyo !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hrdyo !== 1'b1) @(posedge clk);
		q = hrdata;
		chk(hresp, 0, "hresp");
	endtask
////////////////////////////////////////////////////////////
	task t_reset;
		chk(fon, 1, "fast_on");
		chk(mhz, 8, "mhz");
		chk(mode, `MODE_FAST, "mode");
		bus(0, `OFS_SYS_CLOCK_CONTROL, 0);
		chk(q, 0, "sys_ctl");
		bus(0, `OFS_FAST_OSC_CONTROL, 0);
		chk(q & ~32'h2, 1, "osc_ctl");
	endtask

	task t_regs;
		bus(1, `OFS_SYS_CLOCK_CONTROL, 32'hffffff1f);
		bus(0, `OFS_SYS_CLOCK_CONTROL, 0);
		chk(q, 32'h03, "sys_ctl");
		bus(1, `OFS_FAST_OSC_CONTROL, 32'hfffffff1);
		bus(0, `OFS_FAST_OSC_CONTROL, 0);
		chk(q & ~32'h2, 1, "osc_ctl");
		bus(0, 8'h20, 0);
		chk(q, 0, "unmapped");
		bus(1, `OFS_SYS_CLOCK_CONTROL, 0);
	endtask

	task t_freq;
		integer i, c, j, p;
		bus(1, `OFS_FAST_OSC_CONTROL, 0);
		repeat (2) @(posedge clk);
		chk(fon, 0, "fast_on");
		p = 8;
		for (i = 1; i < 5; i = i + 1) begin
			c = i % 4;
			frdy <= 1'b0;
			bus(1, `OFS_FAST_OSC_CONTROL, c * 4 + 1);
			bus(0, `OFS_FAST_OSC_CONTROL, 0);
			chk(q[1], 0, "stable");
			repeat (20) @(posedge clk);
			bus(0, `OFS_FAST_OSC_CONTROL, 0);
			chk(q[1], 0, "stable_wait");
			chk(mhz, p, "mhz_held");
			frdy <= 1'b1;
			for (j = 0; j < 20 && !q[1]; j = j + 1) bus(0, `OFS_FAST_OSC_CONTROL, 0);
			chk(q[1], 1, "stable");
			p = (c == 1) ? 12 : (c == 2) ? 16 : 8;
			chk(mhz, p, "mhz");
		end
		bus(1, `OFS_FAST_OSC_CONTROL, 1);
		bus(0, `OFS_FAST_OSC_CONTROL, 0);
		chk(q[1], 1, "stable_kept");
	endtask

	task t_halt;
		integer k, m;
		for (k = 0; k < 4; k = k + 1) begin
			bus(1, `OFS_SYS_CLOCK_CONTROL, k);
			halt <= 1'b1;
			@(posedge clk);
			halt <= 1'b0;
			repeat (3) @(posedge clk);
			m = (k == 0) ? `MODE_SLEEP : (k == 1) ? `MODE_IDLE_SLOW_ONLY :
				(k == 2) ? `MODE_IDLE_FAST_ONLY : `MODE_IDLE_BOTH_CLOCKS;
			chk(mode, m, "halt_mode");
			chk(fon, k / 2, "fast_on");
			chk(son, k % 2, "slow_on");
			chk(sysclk, 0, "sysclk");
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			repeat (3) @(posedge clk);
			chk(mode, `MODE_FAST, "wake_mode");
		end
	endtask

	task t_switch;
		integer i, n, j, r, e, a;
		reg p;
		bus(1, `OFS_IRQ_ENABLE, 1);
		a = 0;
		for (i = 0; i < 8; i = i + 1) begin
			n = (i + 7) % 8;
			srdy <= (n != 7);
			bus(1, `OFS_SYS_CLOCK_CONTROL, n * 32);
			if (n == 7) begin
				repeat (40) @(posedge clk);
				chk(irq, 0, "slow_wait");
				chk(sysclk, 0, "switch_hold");
				srdy <= 1'b1;
			end
			for (j = 0; j < 1000 && irq !== 1'b1; j = j + 1) @(posedge clk);
			chk(irq, 1, "switch_irq");
			chk(2 * j <= 11 * ((a == 7) ? 16 : 4 << a) + ((n == 7) ? 16 : 4 << n), 1, "switch_time");
			a = n;
			bus(1, `OFS_IRQ_CLEAR, 1);
			bus(0, `OFS_IRQ_STATUS, 0);
			chk(q[0], 0, "irq_status");
			chk(irq, 0, "irq_clear");
			chk(mode, (n == 7) ? `MODE_SLOW : `MODE_FAST, "run_mode");
			r = 0;
			p = sysclk;
			repeat (512) begin
				@(posedge clk);
				if (sysclk && !p) r = r + 1;
				p = sysclk;
			end
			e = (n == 7) ? 32 : 128 >> n;
			chk(r >= e - 1 && r <= e + 1, 1, "sysclk_rate");
		end
	endtask
////////////////////////////////////////////////////////////
	task conclude;
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		errors = errors + 1;
		conclude;
	end

	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		halt = 1'b0;
		wake = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwdata = 32'h0;
		frdy = 1'b1;
		srdy = 1'b1;
		errors = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_regs;
		t_freq;
		t_halt;
		t_switch;
		conclude;
	end
endmodule // tb_top
